/* File: hw/hss_pkg.sv */
// Constants and types shared by the switch control logic.
package hss_pkg;
  // Clock period of the core clock in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Watchdog timeouts in milliseconds for each period setting.
  localparam longint unsigned WD_T00_MS = 620;
  localparam longint unsigned WD_T01_MS = 310;
  localparam longint unsigned WD_T10_MS = 2500;
  localparam longint unsigned WD_T11_MS = 1250;
  localparam longint unsigned PS_PER_MS = 1000000000;
  // Watchdog timeouts as core clock cycles.
  localparam longint unsigned WD_CYC_00 = WD_T00_MS * PS_PER_MS / CLK_PERIOD_PS;
  localparam longint unsigned WD_CYC_01 = WD_T01_MS * PS_PER_MS / CLK_PERIOD_PS;
  localparam longint unsigned WD_CYC_10 = WD_T10_MS * PS_PER_MS / CLK_PERIOD_PS;
  localparam longint unsigned WD_CYC_11 = WD_T11_MS * PS_PER_MS / CLK_PERIOD_PS;
  // Command frame layout.
  localparam int unsigned FRAME_BITS = 8;
  localparam int unsigned CMD_WD_POS = 7;
  localparam int unsigned CMD_ADDR_HI = 6;
  localparam int unsigned CMD_ADDR_LO = 4;
  // Command addresses.
  localparam logic [2:0] ADDR_STAT_SEL = 3'h0;
  localparam logic [2:0] ADDR_OUT_CTRL = 3'h1;
  localparam logic [2:0] ADDR_DIN_CFG = 3'h2;
  localparam logic [2:0] ADDR_MON_SEL = 3'h3;
  localparam logic [2:0] ADDR_WD_PER = 3'h4;
  // Watchdog status word: expired bit position.
  localparam int unsigned WDS_EXPIRED_POS = 2;
  // Fail-safe select codes.
  localparam logic [1:0] FSI_GROUND = 2'h0;
  localparam logic [1:0] FSI_BOTH_OFF = 2'h1;
  localparam logic [1:0] FSI_HS0_ON = 2'h2;
  localparam logic [1:0] FSI_BOTH_ON = 2'h3;
  // Current monitor selection codes.
  localparam logic [1:0] MON_OFF = 2'h0;
  localparam logic [1:0] MON_HS0 = 2'h1;
  localparam logic [1:0] MON_HS1 = 2'h2;
  // Values after reset.
  localparam logic [1:0] RST_2B = 2'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_CNT = 4'h0;
  // Synchronised pin group after reset: chip select reads deselected, the rest low.
  localparam logic [14:0] PIN_SYNC_RST = 15'h4000;
  // Operating modes.
  typedef enum logic [1:0] {HSS_SLEEP, HSS_NORMAL, HSS_FAILSAFE} hss_mode_e;
endpackage

/* File: hw/hss_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/100ps
module hss_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // Both stages take the idle level of their pins on reset, so no false edge follows it.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule

/* File: hw/hss_spi_rx.sv */
// Serial command shifter with daisy-chain data output.
`timescale 1ns/100ps
module hss_spi_rx
  import hss_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [7:0] tx_byte,
  output logic so_o,
  output logic so_oe,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  logic sclk_d_r, cs_d_r, rise, cs_fall, cs_rise;
  logic [7:0] sr_r, sr_nxt, byte_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic valid_nxt, so_nxt, oe_nxt;

  assign rise = sclk & ~sclk_d_r;
  assign cs_fall = cs_d_r & ~cs_n;
  assign cs_rise = ~cs_d_r & cs_n;

  // Shift on rising serial clock while selected, act at deselect.
  always_comb begin
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    valid_nxt = 1'b0;
    byte_nxt = rx_byte;
    if (cs_fall) begin
      sr_nxt = tx_byte;
      cnt_nxt = RST_CNT;
    end else if (!cs_n && rise) begin
      sr_nxt = {sr_r[6:0], sdi};
      if (cnt_r <= 4'(FRAME_BITS)) begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end else if (cs_n) begin
      cnt_nxt = RST_CNT;
    end
    if (cs_rise && cnt_r == 4'(FRAME_BITS)) begin
      valid_nxt = 1'b1;
      byte_nxt = sr_r;
    end
    so_nxt = sr_nxt[7];
    oe_nxt = ~cs_n;
  end

  // Registers of the shifter.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      sr_r <= RST_BYTE;
      cnt_r <= RST_CNT;
      rx_valid <= 1'b0;
      rx_byte <= RST_BYTE;
      so_o <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      sclk_d_r <= sclk;
      cs_d_r <= cs_n;
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      rx_valid <= valid_nxt;
      rx_byte <= byte_nxt;
      so_o <= so_nxt;
      so_oe <= oe_nxt;
    end
  end

  a_shift_sample: assert property (@(posedge clock) disable iff (!resetn)
    (!cs_n && rise && !cs_fall) |=> sr_r[0] == $past(sdi)) else $error("bit not sampled");
  a_cs_ignore: assert property (@(posedge clock) disable iff (!resetn)
    (cs_n && !cs_rise) |=> cnt_r == RST_CNT && !rx_valid) else $error("activity while deselected");
endmodule

/* File: hw/hss_top.sv */
// Serial control, watchdog and output selection of a dual high-side switch.
//
// Overview of operation
// - Command frames are eight bits, most significant first, into a shift register.
// - Serial input is sampled on each rising serial clock edge while selected.
// - Serial output drives only while chip select is low.
// - Serial output changes on each rising serial clock edge.
// - Clock and data are ignored while chip select is high.
// - Commands choose the monitored output or switch the monitor off.
// - Wake rising starts the watchdog.
// - Reset pin low clears configuration and, with wake also low, enters sleep.
// - Reset pin rising starts the watchdog.
// - Direct inputs switch their outputs; their use is set by command.
// - Fault flag pulls low while any fault is present.
// - After timeout the fail-safe select sets outputs: off, both on, or zero only.
// - Grounded fail-safe select disables watchdog and fail-safe.
// - Loss of logic supply clears configuration; direct inputs still work.
// - Battery and logic supply present with wake or reset pin high give normal mode.
// - Watchdog expiry moves the device into fail-safe.
// - Toggling bit seven of a command in time restarts the watchdog.
// - Fail-safe ends on wake and reset both low, or grounded select.
// - Watchdog status bit two reads one in fail-safe.
`timescale 1ns/100ps
module hss_top
  import hss_pkg::*;
#(
  parameter int unsigned WD_CYC_P00 = 32'(hss_pkg::WD_CYC_00),
  parameter int unsigned WD_CYC_P01 = 32'(hss_pkg::WD_CYC_01),
  parameter int unsigned WD_CYC_P10 = 32'(hss_pkg::WD_CYC_10),
  parameter int unsigned WD_CYC_P11 = 32'(hss_pkg::WD_CYC_11)
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo_o,
  output logic spi_sdo_oe,
  input wire logic wake_in,
  input wire logic reset_pin_n,
  input wire logic [1:0] direct_out_ctrl,
  input wire logic [1:0] failsafe_select_in,
  input wire logic logic_supply_ok,
  input wire logic battery_supply,
  input wire logic [3:0] fault_in,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  output logic power_output_zero,
  output logic power_output_one,
  output logic current_monitor_out,
  output logic current_monitor_oe,
  output logic watchdog_expired_flag,
  output logic sleep_mode
);
  import hss_pkg::*;

  // Synchronised copies of the outside pins.
  logic [14:0] pins_s;
  logic cs_s, sclk_s, sdi_s, wake_s, rst_s, vdd_s, bat_s;
  logic [1:0] din_s, fsi_s;
  logic [3:0] fault_s;

  hss_sync #(.W(15), .RST_VAL(PIN_SYNC_RST)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .d({spi_cs_n, spi_sclk, spi_sdi, wake_in, reset_pin_n, direct_out_ctrl,
        failsafe_select_in, logic_supply_ok, battery_supply, fault_in}),
    .q(pins_s)
  );

  // Break the synchronised group into named levels.
  assign {cs_s, sclk_s, sdi_s, wake_s, rst_s, din_s, fsi_s, vdd_s, bat_s, fault_s} = pins_s;

  // Serial shifter and received frame.
  logic rx_valid;
  logic [7:0] rx_byte, tx_byte;
  logic [2:0] rx_addr;
  logic [3:0] rx_data;

  hss_spi_rx u_rx (
    .clock(clock),
    .resetn(resetn),
    .cs_n(cs_s),
    .sclk(sclk_s),
    .sdi(sdi_s),
    .tx_byte(tx_byte),
    .so_o(spi_sdo_o),
    .so_oe(spi_sdo_oe),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte)
  );

  assign rx_addr = rx_byte[CMD_ADDR_HI:CMD_ADDR_LO];
  assign rx_data = rx_byte[3:0];

  // Timeout length for a period setting.
  function automatic logic [31:0] wd_limit(input logic [1:0] per);
    logic [31:0] lim;
    case (per)
      2'h0: lim = WD_CYC_P00;
      2'h1: lim = WD_CYC_P01;
      2'h2: lim = WD_CYC_P10;
      default: lim = WD_CYC_P11;
    endcase
    return lim;
  endfunction

  // Configuration written by commands.
  logic [1:0] cmd_on_r, cmd_on_nxt;
  logic [1:0] din_en_r, din_en_nxt;
  logic [1:0] mon_sel_r, mon_sel_nxt;
  logic [1:0] wd_per_r, wd_per_nxt;
  logic stat_sel_r, stat_sel_nxt;
  logic cfg_clear;

  // Configuration is wiped while the reset pin is low or the logic supply is gone.
  assign cfg_clear = ~rst_s | ~vdd_s;

  // Decode a finished frame into the configuration.
  always_comb begin
    cmd_on_nxt = cmd_on_r;
    din_en_nxt = din_en_r;
    mon_sel_nxt = mon_sel_r;
    wd_per_nxt = wd_per_r;
    stat_sel_nxt = stat_sel_r;
    if (cfg_clear) begin
      cmd_on_nxt = RST_2B;
      din_en_nxt = RST_2B;
      mon_sel_nxt = MON_OFF;
      wd_per_nxt = RST_2B;
      stat_sel_nxt = 1'b0;
    end else if (rx_valid) begin
      case (rx_addr)
        ADDR_STAT_SEL: stat_sel_nxt = rx_data[0];
        ADDR_OUT_CTRL: cmd_on_nxt = rx_data[1:0];
        ADDR_DIN_CFG: din_en_nxt = rx_data[1:0];
        ADDR_MON_SEL: mon_sel_nxt = rx_data[1:0];
        ADDR_WD_PER: wd_per_nxt = rx_data[1:0];
        default: ;
      endcase
    end
  end

  // Configuration registers.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_on_r <= RST_2B;
      din_en_r <= RST_2B;
      mon_sel_r <= MON_OFF;
      wd_per_r <= RST_2B;
      stat_sel_r <= 1'b0;
    end else begin
      cmd_on_r <= cmd_on_nxt;
      din_en_r <= din_en_nxt;
      mon_sel_r <= mon_sel_nxt;
      wd_per_r <= wd_per_nxt;
      stat_sel_r <= stat_sel_nxt;
    end
  end

  // Watchdog and mode state.
  hss_mode_e mode_r, mode_nxt;
  logic wd_run_r, wd_run_nxt;
  logic wd_bit_r, wd_bit_nxt;
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic wake_d_r, rst_d_r;
  logic fsi_gnd, arm, toggled, expire;

  assign fsi_gnd = fsi_s == FSI_GROUND;
  assign arm = (wake_s & ~wake_d_r) | (rst_s & ~rst_d_r);
  assign toggled = rx_valid && rx_byte[CMD_WD_POS] != wd_bit_r;
  assign expire = wd_run_r && mode_r == HSS_NORMAL && wd_cnt_r >= wd_limit(wd_per_r) - 32'h1;

  // Mode transitions and watchdog counting.
  always_comb begin
    mode_nxt = mode_r;
    wd_run_nxt = wd_run_r;
    wd_bit_nxt = wd_bit_r;
    wd_cnt_nxt = wd_cnt_r;
    if (rx_valid) begin
      wd_bit_nxt = rx_byte[CMD_WD_POS];
    end
    if (wd_run_r && mode_r == HSS_NORMAL) begin
      wd_cnt_nxt = wd_cnt_r + 32'h1;
    end
    if (toggled || arm) begin
      wd_cnt_nxt = 32'h0;
    end
    if (arm && !fsi_gnd && (wake_s || rst_s)) begin
      wd_run_nxt = 1'b1;
    end
    case (mode_r)
      HSS_SLEEP: begin
        if ((wake_s || rst_s) && vdd_s && bat_s) begin
          mode_nxt = HSS_NORMAL;
        end
      end
      HSS_NORMAL: begin
        if (!wake_s && !rst_s) begin
          mode_nxt = HSS_SLEEP;
        end else if (expire && !fsi_gnd) begin
          mode_nxt = HSS_FAILSAFE;
        end
      end
      HSS_FAILSAFE: begin
        if (!wake_s && !rst_s) begin
          mode_nxt = HSS_SLEEP;
        end else if (fsi_gnd) begin
          mode_nxt = HSS_NORMAL;
        end
      end
      default: mode_nxt = HSS_SLEEP;
    endcase
    if (fsi_gnd || (!wake_s && !rst_s)) begin
      wd_run_nxt = 1'b0;
      wd_cnt_nxt = 32'h0;
    end
  end

  // Watchdog and mode registers.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_r <= HSS_SLEEP;
      wd_run_r <= 1'b0;
      wd_bit_r <= 1'b0;
      wd_cnt_r <= 32'h0;
      wake_d_r <= 1'b0;
      rst_d_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      wd_run_r <= wd_run_nxt;
      wd_bit_r <= wd_bit_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wake_d_r <= wake_s;
      rst_d_r <= rst_s;
    end
  end

  // Output drive, fault flag, monitor and status words.
  logic hs0_nxt, hs1_nxt, fault_oe_nxt, mon_nxt, mon_oe_nxt;
  logic [7:0] wd_word, fault_word;

  always_comb begin
    hs0_nxt = 1'b0;
    hs1_nxt = 1'b0;
    case (mode_r)
      HSS_FAILSAFE: begin
        hs0_nxt = fsi_s == FSI_BOTH_ON || fsi_s == FSI_HS0_ON;
        hs1_nxt = fsi_s == FSI_BOTH_ON;
      end
      HSS_NORMAL: begin
        hs0_nxt = cmd_on_r[0] | (din_en_r[0] & din_s[0]);
        hs1_nxt = cmd_on_r[1] | (din_en_r[1] & din_s[1]);
        if (!vdd_s) begin
          hs0_nxt = din_s[0];
          hs1_nxt = din_s[1];
        end
      end
      default: ;
    endcase
    fault_oe_nxt = |fault_s;
    mon_oe_nxt = mon_sel_r == MON_HS0 || mon_sel_r == MON_HS1;
    mon_nxt = mon_sel_r == MON_HS1;
    wd_word = {4'h0, 1'b0, mode_r == HSS_FAILSAFE, wd_per_r};
    fault_word = {fsi_s, mode_r == HSS_FAILSAFE, 1'b0, fault_s};
    tx_byte = stat_sel_r ? wd_word : fault_word;
  end

  // Output registers.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_output_zero <= 1'b0;
      power_output_one <= 1'b0;
      fault_flag_n_o <= 1'b0;
      fault_flag_n_oe <= 1'b0;
      current_monitor_out <= 1'b0;
      current_monitor_oe <= 1'b0;
      watchdog_expired_flag <= 1'b0;
      sleep_mode <= 1'b1;
    end else begin
      power_output_zero <= hs0_nxt;
      power_output_one <= hs1_nxt;
      fault_flag_n_o <= 1'b0;
      fault_flag_n_oe <= fault_oe_nxt;
      current_monitor_out <= mon_nxt;
      current_monitor_oe <= mon_oe_nxt;
      watchdog_expired_flag <= mode_r == HSS_FAILSAFE;
      sleep_mode <= mode_r == HSS_SLEEP;
    end
  end

  // Checks on the behaviour above.
  a_so_tristate: assert property (@(posedge clock) disable iff (!resetn)
    cs_s |=> !spi_sdo_oe) else $error("data output driven while deselected");
  a_sleep_clears: assert property (@(posedge clock) disable iff (!resetn)
    !rst_s |=> cmd_on_r == RST_2B && mon_sel_r == MON_OFF) else $error("config kept in reset");
  a_sleep_outputs: assert property (@(posedge clock) disable iff (!resetn)
    mode_r == HSS_SLEEP |=> !power_output_zero && !power_output_one) else $error("output on in sleep");
  a_status_bit: assert property (@(posedge clock) disable iff (!resetn)
    (stat_sel_r && $stable(mode_r)) |-> tx_byte[WDS_EXPIRED_POS] == watchdog_expired_flag)
    else $error("expired bit wrong");
  a_fsi_ground: assert property (@(posedge clock) disable iff (!resetn)
    fsi_gnd |=> mode_r != HSS_FAILSAFE && !wd_run_r) else $error("fail-safe with grounded select");
  a_fs_outputs: assert property (@(posedge clock) disable iff (!resetn)
    (mode_r == HSS_FAILSAFE && fsi_s == FSI_HS0_ON) |=> power_output_zero && !power_output_one)
    else $error("fail-safe outputs wrong");
  a_fault_flag: assert property (@(posedge clock) disable iff (!resetn)
    (|fault_s) |=> fault_flag_n_oe && !fault_flag_n_o) else $error("fault flag not pulled");
  a_supply_loss: assert property (@(posedge clock) disable iff (!resetn)
    !vdd_s |=> din_en_r == RST_2B && wd_per_r == RST_2B) else $error("config kept without supply");
  a_wd_expire: assert property (@(posedge clock) disable iff (!resetn)
    (expire && !fsi_gnd && (wake_s || rst_s)) |=> mode_r == HSS_FAILSAFE) else $error("no fail-safe on expiry");
  a_frame_act: assert property (@(posedge clock) disable iff (!resetn)
    (rx_valid && !cfg_clear && rx_addr == ADDR_MON_SEL) |=> mon_sel_r == $past(rx_data[1:0]))
    else $error("monitor select not taken");
  a_wd_restart: assert property (@(posedge clock) disable iff (!resetn)
    (toggled && wd_run_r && !fsi_gnd && (wake_s || rst_s)) |=> wd_cnt_r == 32'h0) else $error("toggle ignored");
  a_mode_exit: assert property (@(posedge clock) disable iff (!resetn)
    (mode_r == HSS_FAILSAFE && !wake_s && !rst_s) |=> mode_r == HSS_SLEEP) else $error("fail-safe not left");

  // Further checks on monitor release, watchdog arming, direct drive, mode entry and fail-safe outputs.
  a_mon_tristate: assert property (@(posedge clock) disable iff (!resetn)
    (mon_sel_r == MON_OFF) |=> !current_monitor_oe)
    else $error("monitor driven while off");
  a_wake_arm: assert property (@(posedge clock) disable iff (!resetn)
    (wake_s && !wake_d_r && !fsi_gnd) |=> wd_run_r && wd_cnt_r == 32'h0)
    else $error("wake did not arm watchdog");
  a_reset_arm: assert property (@(posedge clock) disable iff (!resetn)
    (rst_s && !rst_d_r && !fsi_gnd) |=> wd_run_r && wd_cnt_r == 32'h0)
    else $error("reset pin did not arm watchdog");
  a_direct_drive: assert property (@(posedge clock) disable iff (!resetn)
    (mode_r == HSS_NORMAL && vdd_s && din_en_r[0] && din_s[0]) |=> power_output_zero)
    else $error("direct input ignored");
  a_supply_direct: assert property (@(posedge clock) disable iff (!resetn)
    (mode_r == HSS_NORMAL && !vdd_s) |=> power_output_zero == $past(din_s[0]) && power_output_one == $past(din_s[1]))
    else $error("outputs not on direct inputs");
  a_normal_entry: assert property (@(posedge clock) disable iff (!resetn)
    (mode_r == HSS_SLEEP && rst_s && vdd_s && bat_s) |=> mode_r == HSS_NORMAL)
    else $error("normal mode not entered");
  a_fs_both_on: assert property (@(posedge clock) disable iff (!resetn)
    (mode_r == HSS_FAILSAFE && fsi_s == FSI_BOTH_ON) |=> power_output_zero && power_output_one)
    else $error("fail-safe outputs not both on");
endmodule

/* File: verification/hss_host.sv */
// Behavioural host that masters the serial command link of the switch.
`timescale 1ns/100ps
module hss_host (
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  // Idle levels: deselected, clock parked low, data at its pull-down level.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // Sends the top nbits of tx MSB first; sel low leaves chip select high.
  // The answer bit is taken at the end of each low phase, where it has settled.
  // A released output reads as the inverse of its last level, so a late enable shows up.
  task automatic xfer(input logic [7:0] tx, input int nbits, input logic sel, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = !sel;
    for (int i = 0; i < nbits; i++) begin
      sdi = tx[7 - i];
      #32;
      rx = {rx[6:0], (sdo_oe === 1'b1) ? sdo_o : !sdo_o};
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
    end
    #32;
    cs_n = 1'b1;
    sdi = 1'b0;
    #32;
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the switch control logic with a behavioural model.
`timescale 1ns/100ps
module tb;
  import hss_pkg::*;
  localparam int WD0 = 2000;
  localparam int WD1 = 1000;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cs_n, sclk, sdi, sdo_o, sdo_oe;
  logic wake_in, reset_pin_n, logic_supply_ok, battery_supply;
  logic [1:0] direct_out_ctrl, failsafe_select_in;
  logic [3:0] fault_in;
  logic ff_o, ff_oe, p0, p1, mon_o, mon_oe, wd_flag, sleep_mode;
  logic [31:0] lfsr = 32'd92853;
  logic [7:0] rx;
  logic [1:0] m_out, m_en, m_mon, e;
  logic m_fs, m_sleep, wdb;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  int lim;

  // Core clock at 250 MHz.
  always #2 clock = ~clock;

  hss_top #(.WD_CYC_P00(WD0), .WD_CYC_P01(WD1), .WD_CYC_P10(8000), .WD_CYC_P11(4000)) dut (
    .clock(clock), .resetn(resetn), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi),
    .spi_sdo_o(sdo_o), .spi_sdo_oe(sdo_oe), .wake_in(wake_in), .reset_pin_n(reset_pin_n),
    .direct_out_ctrl(direct_out_ctrl), .failsafe_select_in(failsafe_select_in),
    .logic_supply_ok(logic_supply_ok), .battery_supply(battery_supply), .fault_in(fault_in),
    .fault_flag_n_o(ff_o), .fault_flag_n_oe(ff_oe), .power_output_zero(p0), .power_output_one(p1),
    .current_monitor_out(mon_o), .current_monitor_oe(mon_oe), .watchdog_expired_flag(wd_flag),
    .sleep_mode(sleep_mode));

  hss_host host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

  // Pseudo-random source for stimulus values.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Waits n cycles and lands just after a rising edge.
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Clears the model configuration as a reset or supply loss does.
  task automatic clr_cfg();
    m_out = 2'b00;
    m_en = 2'b00;
    m_mon = MON_OFF;
  endtask

  // Sends one full command and updates the model once it is accepted.
  task automatic cmd(input logic [2:0] addr, input logic [3:0] data);
    wdb = !wdb;
    host.xfer({wdb, addr, data}, 8, 1'b1, rx);
    cyc(8);
    case (addr)
      ADDR_OUT_CTRL: m_out = data[1:0];
      ADDR_DIN_CFG: m_en = data[1:0];
      ADDR_MON_SEL: m_mon = data[1:0];
      default: m_out = m_out;
    endcase
  endtask

  // Compares every output level with the model.
  task automatic chk_all();
    if (m_sleep) e = 2'b00;
    else if (m_fs) e = (failsafe_select_in == FSI_BOTH_ON) ? 2'b11 : {1'b0, failsafe_select_in == FSI_HS0_ON};
    else if (!logic_supply_ok) e = direct_out_ctrl;
    else e = m_out | (m_en & direct_out_ctrl);
    check("outputs", {6'h00, p1, p0}, {6'h00, e});
    e = (m_mon == MON_OFF) ? 2'b00 : {1'b1, m_mon == MON_HS1};
    check("monitor", {6'h00, mon_oe, mon_o}, {6'h00, e});
    check("fault_flag", {7'h00, ff_oe ? ff_o : 1'b1}, {7'h00, !(|fault_in)});
    check("wd_flag", {7'h00, wd_flag}, {7'h00, m_fs});
    check("sleep", {7'h00, sleep_mode}, {7'h00, m_sleep});
    check("sdo_oe", {7'h00, sdo_oe}, 8'h00);
  endtask

  initial begin
    wake_in = 1'b0;
    reset_pin_n = 1'b0;
    direct_out_ctrl = 2'b00;
    failsafe_select_in = FSI_GROUND;
    logic_supply_ok = 1'b1;
    battery_supply = 1'b0;
    fault_in = 4'h0;
    clr_cfg();
    m_fs = 1'b0;
    m_sleep = 1'b1;
    wdb = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    // Reset pin high without battery keeps the device asleep.
    reset_pin_n = 1'b1;
    cyc(8);
    chk_all();
    battery_supply = 1'b1;
    m_sleep = 1'b0;
    cyc(8);
    chk_all();
    // Each monitor code, with a random fault word read back in the same frame.
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      fault_in = lfsr[3:0];
      cyc(8);
      cmd(ADDR_MON_SEL, 4'(k));
      check("fault_word", rx, {failsafe_select_in, m_fs, 1'b0, fault_in});
      chk_all();
    end
    fault_in = 4'h0;
    cmd(ADDR_OUT_CTRL, 4'h3);
    chk_all();
    // A short frame and a deselected frame must both leave the outputs on.
    host.xfer({!wdb, ADDR_OUT_CTRL, 4'h0}, 7, 1'b1, rx);
    cyc(8);
    chk_all();
    host.xfer({!wdb, ADDR_OUT_CTRL, 4'h0}, 8, 1'b0, rx);
    cyc(8);
    chk_all();
    cmd(ADDR_OUT_CTRL, 4'h0);
    cmd(ADDR_DIN_CFG, 4'h3);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      direct_out_ctrl = lfsr[1:0];
      cyc(8);
      chk_all();
    end
    cmd(ADDR_DIN_CFG, 4'h0);
    direct_out_ctrl = 2'b11;
    cyc(8);
    chk_all();
    // Logic supply loss clears the setup but direct inputs still drive.
    cmd(ADDR_MON_SEL, 4'h1);
    logic_supply_ok = 1'b0;
    clr_cfg();
    direct_out_ctrl = 2'b10;
    cyc(8);
    chk_all();
    logic_supply_ok = 1'b1;
    cyc(8);
    chk_all();
    // Grounded select: no expiry however long the host stays silent.
    cyc(WD0 + 500);
    chk_all();
    for (int code = 1; code < 4; code++) begin
      wake_in = 1'b0;
      reset_pin_n = 1'b0;
      m_sleep = 1'b1;
      clr_cfg();
      cyc(8);
      chk_all();
      failsafe_select_in = 2'(code);
      cyc(8);
      reset_pin_n = 1'b1;
      wake_in = (code == 3);
      m_sleep = 1'b0;
      cmd(ADDR_OUT_CTRL, 4'h3);
      cmd(ADDR_WD_PER, {3'h0, code == 2});
      lim = (code == 2) ? WD1 : WD0;
      for (int k = 0; k < 16; k++) begin
        cmd(ADDR_STAT_SEL, 4'h0);
      end
      chk_all();
      n = 0;
      while (wd_flag !== 1'b1 && n < 3000) begin
        cyc(1);
        n++;
      end
      if (n >= 3000) begin
        error_cnt++;
        final_report();
      end
      check("wd_delay", {7'h00, n >= lim - 24 && n <= lim + 24}, 8'h01);
      m_fs = 1'b1;
      lfsr = lfsr_next(lfsr);
      direct_out_ctrl = lfsr[1:0];
      cyc(8);
      chk_all();
      cmd(ADDR_STAT_SEL, 4'h1);
      cmd(ADDR_STAT_SEL, 4'h1);
      check("wd_word", rx, {5'h00, 1'b1, 1'b0, code == 2});
      if (code == 1) begin
        failsafe_select_in = FSI_GROUND;
      end else begin
        wake_in = 1'b0;
        reset_pin_n = 1'b0;
        m_sleep = 1'b1;
        clr_cfg();
      end
      m_fs = 1'b0;
      cyc(8);
      chk_all();
    end
    final_report();
  end
endmodule
